/* File: test/lpi_engine_tb.sv */
// self-checking bench for the protection engine
`include "lpi_params.svh"
`default_nettype none
module lpi_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLK = 8;
  logic        sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        in_valid, in_ready, meta_valid, meta_ready;
  logic        out_valid, out_ready;
  logic [7:0]  in_data, meta_data, out_data;
  int          n_errors, total_checks;

  lpi_engine #(.BLK_BYTES(BLK), .ADDR_W(5)) u_lpi_engine (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .meta_valid(meta_valid), .meta_data(meta_data),
    .meta_ready(meta_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));

  lpi_host_model u_lpi_host_model (
    .sys_clk(sys_clk), .reset_n(reset_n), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .meta_valid(meta_valid),
    .meta_data(meta_data), .meta_ready(meta_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out();
    n_errors++;
    $display("ERROR %0t wait ran out", $time);
    tally_and_finish();
  endtask

  // one avalon access; request held until waitrequest seen low
  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) timed_out();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `LPI_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {b[i], 8'h00};
      for (int k = 0; k < 8; k++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ `LPI_CRC_POLY) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // bad: 1 guard, 2 app bit0, 3 ref, 4 app escape with bad guard
  task automatic run(input logic [31:0] cfg, input logic [31:0] cmd,
                     input logic [31:0] tag, input int bad,
                     input logic [2:0] code);
    logic [7:0]  dat[$];
    logic [7:0]  meta[$];
    logic [7:0]  exp[$];
    logic [63:0] f;
    logic [31:0] rtag, r;
    logic [15:0] g, app;
    int          mb, fo, n, nb;
    logic        ins;
    mb   = cfg[15:8];
    fo   = cfg[2] ? 0 : mb - 8;
    nb   = cmd[15:0];
    ins  = cfg[1:0] != 2'h0 && cmd[29] && !cmd[24];
    rtag = $urandom & 32'h7fff_ffff;
    for (int b = 0; b < nb; b++) begin
      dat.delete();
      meta.delete();
      for (int i = 0; i < BLK; i++) dat.push_back(8'($urandom));
      for (int i = 0; i < mb; i++) meta.push_back(8'($urandom));
      g   = crc16(dat);
      app = tag[15:0];
      r   = rtag + 32'(b);
      if (b == nb - 1) begin
        g   = (bad == 1 || bad == 4) ? g ^ 16'h0001 : g;
        app = (bad == 2) ? app ^ 16'h0001 : (bad == 4 ? 16'hffff : app);
        r   = (bad == 3) ? r + 32'h1 : r;
      end
      f = {g, app, r};
      for (int k = 0; k < 8; k++) meta[fo + k] = f[63 - 8 * k -: 8];
      foreach (dat[i]) u_lpi_host_model.in_q.push_back(dat[i]);
      // inserting: the host leaves out the eight field bytes
      for (int i = 0; i < mb; i++) begin
        if (ins && i >= fo && i < fo + 8) continue;
        if (cfg[3]) u_lpi_host_model.meta_q.push_back(meta[i]);
        else u_lpi_host_model.in_q.push_back(meta[i]);
      end
      exp = {exp, dat, meta};
    end
    av(1'b1, `LPI_REG_CFG, cfg);
    av(1'b0, `LPI_REG_CFG, 32'h0);
    chk(rd, cfg);
    av(1'b1, `LPI_REG_TAG, tag);
    av(1'b1, `LPI_REG_REF, rtag);
    av(1'b1, `LPI_REG_CMD, cmd | 32'h8000_0000);
    n = 0;
    do begin
      av(1'b0, `LPI_REG_STAT, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 2000);
    if (n >= 2000) timed_out();
    chk(rd[4:2], code);
    if (code == `LPI_ST_OK) begin
      chk(rd[31:16], nb);
      n = 0;
      while (!cmd[24] && u_lpi_host_model.out_q.size() < exp.size()
             && n < 1000) begin
        @(posedge sys_clk);
        n++;
      end
      if (n >= 1000) timed_out();
      if (cmd[24]) exp.delete();
      chk(u_lpi_host_model.out_q.size(), exp.size());
      foreach (exp[i]) begin
        chk(u_lpi_host_model.out_q[i], exp[i]);
      end
    end
    av(1'b1, `LPI_REG_STAT, 32'h2);
    av(1'b0, `LPI_REG_STAT, 32'h0);
    chk(rd[1], 1'b0);
    u_lpi_host_model.in_q.delete();
    u_lpi_host_model.meta_q.delete();
    // a stalled media byte must land before the queue is emptied
    n = 0;
    while (out_valid && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 100) timed_out();
    repeat (4) @(posedge sys_clk);
    u_lpi_host_model.out_q.delete();
  endtask

  localparam logic [31:0] CFGS [14] = '{32'h0800, 32'h0801, 32'h0802,
    32'h0801, 32'h0802, 32'h0801, 32'h0801, 32'h0802, 32'h100b,
    32'h1005, 32'h1005, 32'h100e, 32'h0803, 32'h0801};
  localparam logic [31:0] CMDS [14] = '{32'h1c00_0000, 32'h1c00_0000,
    32'h1c00_0000, 32'h1c00_0000, 32'h1c00_0000, 32'h0c00_0000,
    32'h1c00_0000, 32'h1c00_0000, 32'h3c00_0000, 32'h1d00_0000,
    32'h1d00_0000, 32'h1000_0000, 32'h1c00_0000, 32'h1c00_0000};
  localparam int BADS [14] = '{1, 0, 1, 2, 3, 1, 4, 4, 0, 0, 3, 2, 4, 2};
  localparam logic [2:0] CODES [14] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3,
    3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h3, 3'h0, 3'h1, 3'h0};
  localparam logic [4:0] ADRS [7] = '{5'h00, 5'h04, 5'h08, 5'h0c,
    5'h10, 5'h14, 5'h1c};

  initial begin
    logic [15:0] mask;
    n_errors       = 0;
    total_checks   = 0;
    reset_n        = 1'b0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 5'h00;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    void'($urandom(32'hb794dfa8));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    av(1'b1, 5'h14, 32'h1234_5678);
    foreach (ADRS[i]) begin
      av(1'b0, ADRS[i], 32'h0);
      chk(rd, (i == 0) ? `LPI_CFG_RST : 32'h0);
    end
    // lanes 0 and 2 only
    avs_byteenable <= 4'h5;
    av(1'b1, `LPI_REG_REF, 32'haabb_ccdd);
    avs_byteenable <= 4'hf;
    av(1'b0, `LPI_REG_REF, 32'h0);
    chk(rd, 32'h00bb_00dd);
    for (int s = 0; s < 14; s++) begin
      u_lpi_host_model.stall = (s % 2) ? 60 : 0;
      // masked app bit must not fail the check
      mask = (s == 13) ? 16'hfffe : 16'hffff;
      run(CFGS[s], CMDS[s] | (1 + $urandom % 3),
          {mask, 16'($urandom % 16'hfff0)}, BADS[s], CODES[s]);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: test/lpi_host_model.sv */
// host memory and media side model for the protection engine
`default_nettype none
module lpi_host_model (
  input  wire logic       sys_clk,     // core clock
  input  wire logic       reset_n,     // async reset
  output logic            in_valid,    // host byte valid
  output logic      [7:0] in_data,     // host byte
  input  wire logic       in_ready,    // engine took byte
  output logic            meta_valid,  // separate meta byte valid
  output logic      [7:0] meta_data,   // separate meta byte
  input  wire logic       meta_ready,  // engine took meta byte
  input  wire logic       out_valid,   // media byte valid
  input  wire logic [7:0] out_data,    // media byte
  output logic            out_ready    // media accepts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] in_q[$];
  logic [7:0] meta_q[$];
  logic [7:0] out_q[$];
  int         stall = 0;
  // idle data lines toggle so a stale byte is never mistaken for fresh
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_valid   <= 1'b0;
      in_data    <= 8'h00;
      meta_valid <= 1'b0;
      meta_data  <= 8'h00;
      out_ready  <= 1'b0;
    end else begin
      if (in_valid && in_ready) void'(in_q.pop_front());
      if (meta_valid && meta_ready) void'(meta_q.pop_front());
      in_valid   <= in_q.size() > 0;
      in_data    <= (in_q.size() > 0) ? in_q[0] : ~in_data;
      meta_valid <= meta_q.size() > 0;
      meta_data  <= (meta_q.size() > 0) ? meta_q[0] : ~meta_data;
      if (out_valid && out_ready) out_q.push_back(out_data);
      out_ready  <= ($urandom % 100) >= stall;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/lpi_crc.sv */
// bytewise guard crc, msb first, no reflection or final inversion
`include "lpi_params.svh"
`default_nettype none
module lpi_crc (
  input  wire logic    sys_clk,  // core clock
  input  wire logic    reset_n,  // async reset
  lpi_crc_if.crc_unit  bus       // clear, byte strobe, result
);
  import lpi_pkg::*;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `LPI_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [15:0] crc;
  wire  [15:0] next_crc = bus.clear ? `LPI_CRC_INIT :
                          bus.en ? crc_byte(crc, bus.data) : crc;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) crc <= `LPI_CRC_INIT;
    else crc <= next_crc;
  end
  assign bus.crc = crc;
endmodule
`default_nettype wire

/* File: verilog/lpi_crc_if.sv */
// carrier between the engine and its guard crc unit
`default_nettype none
interface lpi_crc_if;
  logic        clear;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport eng (output clear, output en, output data, input crc);
  modport crc_unit (input clear, input en, input data, output crc);
endinterface
`default_nettype wire

/* File: verilog/lpi_engine.sv */
// per-block protection field pass, check and insert engine
// Behaviour
// - extended mode: metadata follows block data
// - separate mode: metadata from its own meta stream
// - transfer mode fixed, never mixed per command
// - eight-byte metadata is whole protection field
// - larger metadata: field first or last eight
// - protection type set at format, readable back
// - guard holds crc over block data
// - only crc guard, no checksum option
// - app tag only compared or escape-detected
// - reference tag catches misplaced blocks
// - unprotected namespace passes bytes unchanged
// - pass action: host field checked in flight
// - failed check ends with its status code
// - insert action: device generates protection field
// - only eight field bytes replaced, size kept
// - compare checks like read, returns nothing
// - bits 28,27,26 enable guard, app, ref
// - masked app compare; reference tag increments
// - escape values disable checks per type
// - inserted field: crc, expected tag, running ref
//
// The Avalon-MM register port and the register addresses were decided locally.
`include "lpi_params.svh"
`default_nettype none
module lpi_engine #(
  parameter int BLK_BYTES = 512,  // data bytes per block
  parameter int ADDR_W    = 5     // avalon byte address width
) (
  input  wire logic              sys_clk,            // core clock
  input  wire logic              reset_n,            // async reset
  input  wire logic [ADDR_W-1:0] avs_address,        // byte address
  input  wire logic              avs_read,           // read request
  input  wire logic              avs_write,          // write request
  input  wire logic [31:0]       avs_writedata,      // write data
  input  wire logic [3:0]        avs_byteenable,     // write lanes
  output logic      [31:0]       avs_readdata,       // read data
  output logic                   avs_waitrequest,    // stall
  input  wire logic              in_valid,           // host byte valid
  input  wire logic [7:0]        in_data,            // host byte
  output logic                   in_ready,           // host byte taken
  input  wire logic              meta_valid,         // meta byte valid
  input  wire logic [7:0]        meta_data,          // meta byte
  output logic                   meta_ready,         // meta byte taken
  output logic                   out_valid,          // media byte valid
  output logic      [7:0]        out_data,           // media byte
  input  wire logic              out_ready           // media takes byte
);
  import lpi_pkg::*;

  localparam logic [15:0] BLK_LAST = 16'(BLK_BYTES - 1);

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  // register file
  logic [31:0]  cfg;
  logic [31:0]  cmd;
  logic [31:0]  tag_reg;
  logic [31:0]  ref_reg;
  logic         done;
  logic [2:0]   status_code;
  logic [15:0]  blk_done;

  // command latched at start, so the mode cannot change mid command
  lpi_pi_type_t act_type;
  lpi_op_t      act_op;
  logic         act_first;
  logic         act_sep;
  logic         act_protection_action_bit;
  logic [2:0]   act_chk;
  logic [7:0]   act_meta;
  logic [15:0]  act_app;
  logic [15:0]  act_mask;

  lpi_state_t   state;
  logic [15:0]  data_cnt;
  logic [7:0]   meta_cnt;
  logic [15:0]  blk_left;
  logic [31:0]  exp_ref;
  logic [63:0]  pi_rx;

  lpi_crc_if crc_bus ();
  lpi_crc u_crc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .bus     (crc_bus.crc_unit)
  );

  // bus decode
  wire        bus_req  = avs_read | avs_write;
  wire        wr_hit   = avs_write & ~avs_waitrequest;
  wire        idle     = (state == LPI_IDLE);
  wire        sel_cfg  = (avs_address == `LPI_REG_CFG);
  wire        sel_cmd  = (avs_address == `LPI_REG_CMD);
  wire        sel_tag  = (avs_address == `LPI_REG_TAG);
  wire        sel_ref  = (avs_address == `LPI_REG_REF);
  wire        sel_stat = (avs_address == `LPI_REG_STAT);
  wire [31:0] cmd_new  = merge(cmd, avs_writedata, avs_byteenable);
  // a start written before the last media byte has left is dropped
  wire        go       = wr_hit & sel_cmd & cmd_new[`LPI_CMD_GO]
                         & idle & ~out_valid;
  wire        done_clr = wr_hit & sel_stat & avs_byteenable[0]
                         & avs_writedata[1];
  wire [31:0] stat_rd  = {blk_done, 11'h000, status_code, done, ~idle};
  wire [31:0] rd_mux   = sel_cfg  ? cfg :
                         sel_cmd  ? {1'b0, cmd[30:0]} :
                         sel_tag  ? tag_reg :
                         sel_ref  ? ref_reg :
                         sel_stat ? stat_rd : 32'h0000_0000;

  // byte path decode
  wire       prot    = (act_type != LPI_PI_NONE);
  wire [7:0] pi_off  = act_first ? 8'h00 : act_meta - `LPI_PI_BYTES;
  wire [7:0] pi_rel  = meta_cnt - pi_off;
  wire       in_pi   = (state == LPI_META) & prot
                       & (meta_cnt >= pi_off) & (pi_rel < `LPI_PI_BYTES);
  wire [2:0] pi_idx  = pi_rel[2:0];
  wire       insert  = act_protection_action_bit & (act_op == LPI_OP_WRITE);
  wire       gen     = in_pi & insert;
  wire       use_mp  = (state == LPI_META) & act_sep;
  wire [7:0] src     = use_mp ? meta_data : in_data;
  wire       moving  = (state == LPI_DATA) | (state == LPI_META);
  wire       slot    = moving & ~out_valid;
  wire       hs_in   = in_ready & in_valid;
  wire       hs_meta = meta_ready & meta_valid;
  wire       step    = gen ? slot : (hs_in | hs_meta);
  wire       data_end = (state == LPI_DATA) & (data_cnt == BLK_LAST);
  wire       meta_end = (state == LPI_META)
                        & (meta_cnt == act_meta - 8'h01);

  // generated field, most significant byte first
  wire [63:0] gen_pi  = {crc_bus.crc, act_app, exp_ref};
  wire [7:0]  gen_b   = gen_pi[8'd63 - {pi_idx, 3'b000} -: 8];
  wire [7:0]  byte_v  = gen ? gen_b : src;

  // received field split
  wire [15:0] pi_guard = pi_rx[63:48];
  wire [15:0] pi_app   = pi_rx[47:32];
  wire [31:0] pi_ref   = pi_rx[31:0];
  wire        esc1  = (act_type == LPI_PI_T1) & (pi_app == `LPI_APP_OFF);
  wire        esc2  = (act_type == LPI_PI_T2) & (pi_app == `LPI_APP_OFF)
                      & (pi_ref == `LPI_REF_OFF);
  // inserting writes have no host field to check
  wire        chk_on = prot & ~insert & ~esc1 & ~esc2;
  wire        g_err  = chk_on & act_chk[2]
                       & (pi_guard != crc_bus.crc);
  wire        a_err  = chk_on & act_chk[1]
                       & (((pi_app ^ act_app) & act_mask) != 16'h0000);
  wire        r_err  = chk_on & act_chk[0] & (pi_ref != exp_ref);
  wire        any_err = g_err | a_err | r_err;
  wire [2:0]  err_code = g_err ? `LPI_ST_GUARD :
                         a_err ? `LPI_ST_APP : `LPI_ST_REF;
  wire        chk_st  = (state == LPI_CHK);
  wire        finish  = chk_st & (any_err | (blk_left == 16'h0001));
  wire        go_zero = go & (cmd_new[15:0] == 16'h0000);

  assign crc_bus.clear = chk_st | go;
  assign crc_bus.en    = step & (state == LPI_DATA) & prot;
  assign crc_bus.data  = src;

  // avalon slave: one wait cycle per access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest) avs_readdata <= rd_mux;
    end
  end

  // format changes only between commands
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg     <= `LPI_CFG_RST;
      cmd     <= `LPI_CMD_RST;
      tag_reg <= 32'h0000_0000;
      ref_reg <= 32'h0000_0000;
    end else begin
      if (wr_hit & sel_cfg & idle)
        cfg <= merge(cfg, avs_writedata, avs_byteenable);
      // go is a strobe: never stored, so a partial write cannot restart
      if (wr_hit & sel_cmd & idle) cmd <= {1'b0, cmd_new[30:0]};
      if (wr_hit & sel_tag) tag_reg <= merge(tag_reg, avs_writedata,
                                             avs_byteenable);
      if (wr_hit & sel_ref) ref_reg <= merge(ref_reg, avs_writedata,
                                             avs_byteenable);
    end
  end

  // completion status; a finish beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done        <= 1'b0;
      status_code <= `LPI_ST_OK;
      blk_done    <= 16'h0000;
    end else begin
      done <= finish | go_zero | (done & ~done_clr);
      if (go) begin
        status_code <= `LPI_ST_OK;
        blk_done    <= 16'h0000;
      end else if (chk_st) begin
        if (any_err) status_code <= err_code;
        else blk_done <= blk_done + 16'h0001;
      end
    end
  end

  // latch the command and format at start
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_type  <= LPI_PI_NONE;
      act_op    <= LPI_OP_WRITE;
      act_first <= 1'b0;
      act_sep   <= 1'b0;
      act_protection_action_bit <= 1'b0;
      act_chk   <= 3'h0;
      act_meta  <= 8'h00;
      act_app   <= 16'h0000;
      act_mask  <= 16'h0000;
    end else if (go) begin
      act_type  <= lpi_pi_type_t'(cfg[`LPI_CFG_TYPE_LO +: 2]);
      act_first <= cfg[`LPI_CFG_FIRST];
      act_sep   <= cfg[`LPI_CFG_SEP];
      act_meta  <= cfg[`LPI_CFG_META_LO +: 8];
      act_op    <= lpi_op_t'(cmd_new[`LPI_CMD_OP]);
      act_protection_action_bit <= cmd_new[`LPI_CMD_PROTECTION_ACTION_BIT];
      act_chk   <= cmd_new[`LPI_CMD_CHK_LO +: 3];
      act_app   <= tag_reg[15:0];
      act_mask  <= tag_reg[31:16];
    end
  end

  // block sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= LPI_IDLE;
      data_cnt <= 16'h0000;
      meta_cnt <= 8'h00;
      blk_left <= 16'h0000;
      exp_ref  <= 32'h0000_0000;
    end else begin
      case (state)
        LPI_IDLE: begin
          data_cnt <= 16'h0000;
          meta_cnt <= 8'h00;
          if (go & ~go_zero) begin
            blk_left <= cmd_new[15:0];
            exp_ref  <= ref_reg;
            state    <= LPI_DATA;
          end
        end
        LPI_DATA: begin
          if (step) begin
            data_cnt <= data_cnt + 16'h0001;
            if (data_end)
              state <= (act_meta == 8'h00) ? LPI_CHK : LPI_META;
          end
        end
        LPI_META: begin
          if (step) begin
            meta_cnt <= meta_cnt + 8'h01;
            if (meta_end) state <= LPI_CHK;
          end
        end
        LPI_CHK: begin
          data_cnt <= 16'h0000;
          meta_cnt <= 8'h00;
          blk_left <= blk_left - 16'h0001;
          exp_ref  <= exp_ref + 32'h0000_0001;
          state    <= finish ? LPI_IDLE : LPI_DATA;
        end
        default: state <= LPI_IDLE;
      endcase
    end
  end

  // byte mover; ready drops after each take, back a cycle after out_valid is seen low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_ready   <= 1'b0;
      meta_ready <= 1'b0;
      out_valid  <= 1'b0;
      out_data   <= 8'h00;
      pi_rx      <= 64'h0;
    end else begin
      in_ready   <= slot & ~gen & ~use_mp & ~hs_in;
      meta_ready <= slot & ~gen & use_mp & ~hs_meta;
      if (step & (act_op == LPI_OP_WRITE)) begin
        out_valid <= 1'b1;
        out_data  <= byte_v;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (step & in_pi & ~gen) pi_rx <= {pi_rx[55:0], src};
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  bus_wait_a: assert property (
    bus_req & avs_waitrequest |=> ~avs_waitrequest)
    else $error("access not answered after one wait cycle");
  pass_plain_a: assert property (
    step & ~prot & (act_op == LPI_OP_WRITE)
    |=> out_valid & (out_data == $past(src)))
    else $error("unprotected byte altered");
  cmp_quiet_a: assert property (
    ~idle & (act_op == LPI_OP_CMP) |-> ~out_valid)
    else $error("compare returned data");
  gen_guard_a: assert property (
    step & gen & (pi_idx == 3'h0)
    |=> out_data == $past(crc_bus.crc[15:8]))
    else $error("inserted guard is not the crc");
  keep_meta_a: assert property (
    step & (state == LPI_META) & ~in_pi & (act_op == LPI_OP_WRITE)
    |=> out_data == $past(src))
    else $error("non-field metadata byte changed");
  ref_step_a: assert property (
    chk_st & ~finish |=> exp_ref == $past(exp_ref) + 32'h0000_0001)
    else $error("reference tag not advanced");
  guard_code_a: assert property (
    chk_st & g_err |=> done & (status_code == `LPI_ST_GUARD) & idle)
    else $error("guard failure not reported");
  escape_one_a: assert property (
    chk_st & esc1 & (status_code == `LPI_ST_OK)
    |=> status_code == `LPI_ST_OK)
    else $error("escaped block raised an error");
  data_port_a: assert property (
    (state == LPI_DATA) | ((state == LPI_META) & ~act_sep) |-> ~meta_ready)
    else $error("metadata port used outside separate mode");
  mode_hold_a: assert property (
    ~idle & ~$past(idle) |-> $stable(act_sep) & $stable(act_first))
    else $error("transfer mode changed in a command");

  insert_seen_c: cover property (step & gen);
  guard_fail_c: cover property (chk_st & g_err);
  cmp_done_c: cover property (finish & (act_op == LPI_OP_CMP) & ~any_err);
  sep_meta_c: cover property (hs_meta);
endmodule
`default_nettype wire

/* File: verilog/lpi_params.svh */
// offsets, field positions, reset values and codes of the protection engine
`ifndef LPI_PARAMS_SVH
`define LPI_PARAMS_SVH

// register byte offsets
`define LPI_REG_CFG     5'h00
`define LPI_REG_CMD     5'h04
`define LPI_REG_TAG     5'h08
`define LPI_REG_REF     5'h0c
`define LPI_REG_STAT    5'h10

// format register fields
`define LPI_CFG_TYPE_LO 0
`define LPI_CFG_FIRST   2
`define LPI_CFG_SEP     3
`define LPI_CFG_META_LO 8
`define LPI_CFG_RST     32'h0000_0800

// command register fields
`define LPI_CMD_GO      31
`define LPI_CMD_PROTECTION_ACTION_BIT   29
`define LPI_CMD_CHK_LO  26
`define LPI_CMD_OP      24
`define LPI_CMD_RST     32'h0000_0000

// protection field layout and escape values
`define LPI_PI_BYTES    8'h08
`define LPI_APP_OFF     16'hffff
`define LPI_REF_OFF     32'hffff_ffff
`define LPI_CRC_POLY    16'h8bb7
`define LPI_CRC_INIT    16'h0000

// completion codes
`define LPI_ST_OK       3'h0
`define LPI_ST_GUARD    3'h1
`define LPI_ST_APP      3'h2
`define LPI_ST_REF      3'h3

`endif

/* File: verilog/lpi_pkg.sv */
// types shared by the protection engine
`default_nettype none
package lpi_pkg;
  typedef enum logic [1:0] {
    LPI_PI_NONE, LPI_PI_T1, LPI_PI_T2, LPI_PI_T3
  } lpi_pi_type_t;
  typedef enum logic {LPI_OP_WRITE, LPI_OP_CMP} lpi_op_t;
  typedef enum logic [1:0] {
    LPI_IDLE, LPI_DATA, LPI_META, LPI_CHK
  } lpi_state_t;
endpackage
`default_nettype wire
